//--- wdr_defs.svh
`ifndef WDR_DEFS_SVH
`define WDR_DEFS_SVH

// register indices on the plain register port
`define WDR_ADDR_CTRL       2'h0
`define WDR_ADDR_STATUS     2'h1
`define WDR_ADDR_PORT_DATA  2'h2
`define WDR_ADDR_PORT_DIR   2'h3

// watchdog_control fields
`define WDR_CTRL_SYSCLK_BIT 7
`define WDR_CTRL_SEL_MSB    6
`define WDR_CTRL_SEL_LSB    4
`define WDR_CTRL_RESET      8'h7A

// status fields
`define WDR_STAT_EXPIRY_BIT 0
`define WDR_STAT_PD_BIT     1

`define WDR_PORT_RESET      8'hFF

// timing
`define WDR_CLK_PERIOD_NS   10
`define WDR_POD_NS          100000000
`define WDR_UV_FILTER_NS    1000
`define WDR_SST_FAST_EDGES  16
`define WDR_SST_SLOW_EDGES  2
`define WDR_TIMEOUT_BASE    16'h0100

`endif

//--- wdr_pkg.sv
`include "wdr_defs.svh"

package wdr_pkg;

    typedef enum {
        ST_HOLD,
        ST_RUN,
        ST_SLEEP,
        ST_IDLE0,
        ST_IDLE1,
        ST_SETTLE
    } wdr_state_t;

    // last count before overflow for a period select code
    function automatic logic [14:0] wdr_limit(input logic [2:0] sel);
        logic [15:0] span;
        span = 16'(`WDR_TIMEOUT_BASE << sel);
        return 15'(span - 16'h0001);
    endfunction

endpackage

//--- wdr_wdt_if.sv
`timescale 1ns/10ps
`default_nettype none

interface wdr_wdt_if;
    logic        tick;
    logic        clear;
    logic [2:0]  period_sel;
    logic        overflow;
    logic [14:0] count;

    modport ctl (output tick, output clear, output period_sel, input overflow, input count);
    modport tmr (input tick, input clear, input period_sel, output overflow, output count);
endinterface

`default_nettype wire

//--- wdr_timer.sv
`timescale 1ns/10ps
`default_nettype none

module wdr_timer
    import wdr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    wdr_wdt_if.tmr    wdt
);

    logic [14:0] count_q;
    logic [14:0] count_d;
    logic        ovf_q;
    logic        ovf_d;

    always_comb begin
        count_d = count_q;
        ovf_d   = 1'b0;
        if (wdt.clear) begin
            count_d = 15'h0000;
        end else if (wdt.tick) begin
            // >= so that shrinking the period mid-count cannot run the chain up to its wrap
            if (count_q >= wdr_limit(wdt.period_sel)) begin
                count_d = 15'h0000;
                ovf_d   = 1'b1;
            end else begin
                count_d = 15'(count_q + 15'h0001);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= 15'h0000;
            ovf_q   <= 1'b0;
        end else begin
            count_q <= count_d;
            ovf_q   <= ovf_d;
        end
    end

    assign wdt.count    = count_q;
    assign wdt.overflow = ovf_q;

    a_clear_zeroes_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdt.clear |=> count_q == 15'h0000 && !ovf_q) else $error("clear did not zero the counter");
    a_overflow_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(ovf_q) |-> $past(count_q) >= wdr_limit($past(wdt.period_sel)) && count_q == 15'h0000)
        else $error("overflow away from selected limit");

endmodule // wdr_timer

`default_nettype wire

//--- wdr_top.sv
// Behaviour
// - watchdog counts slow oscillator cycles, divided by 2^8 up to 2^15.
// - control bits 6..4 select timeout 256 cycles doubling up to 32768.
// - control bit 7 keeps system clock running in idle when set.
// - control bits 3..0 are plain read/write storage.
// - watchdog always runs; software cannot disable it.
// - counter overflow generates a reset; software must clear before then.
// - counter cleared by hardware reset, clear instruction or halt instruction.
// - one clear instruction alone clears the counter.
// - timeout while running equals power-on reset but sets expiry flag and keeps powerdown flag.
// - timeout in sleep or idle clears only pc and sp, sets expiry.
// - timeout wake waits 15-16 fast or 1-2 slow oscillator cycles.
// - power-on reset sets program counter to zero.
// - power-on reset sets port data and direction registers to all ones.
// - power-on, undervoltage or running timeout reset held for power-on delay.
// - undervoltage reset only after indication outlasts filter time.
// - undervoltage reset always enabled; threshold fixed by configuration option.
// - flags zero on power-on, kept on undervoltage; timeouts set them as listed.
// - halt clears counter, sets powerdown flag, clears expiry flag.
// - powerdown flag cleared by power-up or clear instruction, set by halt.
// - halt with idle select enters idle, clock kept if bit 7 set.
`timescale 1ns/10ps
`default_nettype none
`include "wdr_defs.svh"

module wdr_top
    import wdr_pkg::*;
#(
    parameter int unsigned       POD_CYCLES   = `WDR_POD_NS / `WDR_CLK_PERIOD_NS,
    parameter logic [1:0]        UV_THRESHOLD = 2'h0
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        slow_rc_osc,
    input  wire logic        fast_rc_osc,
    input  wire logic        sys_src_slow,
    input  wire logic        undervolt,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        halt_instr,
    input  wire logic        idle_select,
    input  wire logic        wake_req,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             core_reset,
    output logic             cpu_hold,
    output logic             pc_sp_clear,
    output logic             sysclk_enable,
    output logic      [1:0]  uv_threshold,
    output logic      [7:0]  port_out,
    output logic      [7:0]  port_dir
);

    localparam int UV_CYCLES = (`WDR_UV_FILTER_NS + `WDR_CLK_PERIOD_NS - 1) / `WDR_CLK_PERIOD_NS;
    localparam int POD_W     = $clog2(POD_CYCLES + 1);

    // pin synchronisers; third stage only feeds the edge detectors
    logic [2:0] slow_sync_q;
    logic [2:0] fast_sync_q;
    logic [1:0] uv_sync_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slow_sync_q <= 3'h0;
            fast_sync_q <= 3'h0;
            uv_sync_q   <= 2'h0;
        end else begin
            slow_sync_q <= {slow_sync_q[1:0], slow_rc_osc};
            fast_sync_q <= {fast_sync_q[1:0], fast_rc_osc};
            uv_sync_q   <= {uv_sync_q[0], undervolt};
        end
    end

    logic slow_tick;
    logic fast_tick;
    logic uv_level;
    assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];
    assign fast_tick = fast_sync_q[1] & ~fast_sync_q[2];
    assign uv_level  = uv_sync_q[1];

    // undervoltage filter
    logic [15:0] uv_cnt_q;
    logic [15:0] uv_cnt_d;
    logic        uv_fire;

    always_comb begin
        uv_cnt_d = 16'h0000;
        uv_fire  = 1'b0;
        if (uv_level) begin
            if (uv_cnt_q == 16'(UV_CYCLES - 1)) begin
                uv_fire  = 1'b1;
                uv_cnt_d = uv_cnt_q;
            end else begin
                uv_cnt_d = 16'(uv_cnt_q + 16'h0001);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            uv_cnt_q <= 16'h0000;
        end else begin
            uv_cnt_q <= uv_cnt_d;
        end
    end

    wdr_wdt_if wdt ();

    wdr_timer u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wdt     (wdt.tmr)
    );

    // main state, flags and registers
    wdr_state_t       state_q;
    wdr_state_t       state_d;
    logic [POD_W-1:0] hold_cnt_q;
    logic [POD_W-1:0] hold_cnt_d;
    logic [4:0]       sst_cnt_q;
    logic [4:0]       sst_cnt_d;
    logic             sst_slow_q;
    logic             sst_slow_d;
    logic [7:0]       ctrl_q;
    logic [7:0]       ctrl_d;
    logic [7:0]       pdata_q;
    logic [7:0]       pdata_d;
    logic [7:0]       pdir_q;
    logic [7:0]       pdir_d;
    logic             exp_q;
    logic             exp_d;
    logic             pd_q;
    logic             pd_d;
    logic             pcsp_q;
    logic             pcsp_d;
    logic             wdt_clear;
    logic             full_reset;
    logic             asleep;

    assign asleep = (state_q == ST_SLEEP) || (state_q == ST_IDLE0) || (state_q == ST_IDLE1);
    assign full_reset = uv_fire || (wdt.overflow && !asleep);

    always_comb begin
        state_d    = state_q;
        hold_cnt_d = hold_cnt_q;
        sst_cnt_d  = sst_cnt_q;
        sst_slow_d = sst_slow_q;
        ctrl_d     = ctrl_q;
        pdata_d    = pdata_q;
        pdir_d     = pdir_q;
        exp_d      = exp_q;
        pd_d       = pd_q;
        pcsp_d     = 1'b0;
        wdt_clear  = 1'b0;

        if (reg_wr) begin
            case (reg_addr)
                `WDR_ADDR_CTRL:      ctrl_d  = reg_wdata;
                `WDR_ADDR_PORT_DATA: pdata_d = reg_wdata;
                `WDR_ADDR_PORT_DIR:  pdir_d  = reg_wdata;
                default: ;
            endcase
        end

        case (state_q)
            ST_HOLD: begin
                wdt_clear = 1'b1;
                if (hold_cnt_q == POD_W'(POD_CYCLES - 1)) begin
                    state_d = ST_RUN;
                end else begin
                    hold_cnt_d = POD_W'(hold_cnt_q + 1'b1);
                end
            end
            ST_RUN: begin
                if (halt_instr) begin
                    wdt_clear = 1'b1;
                    pd_d      = 1'b1;
                    exp_d     = 1'b0;
                    if (!idle_select) begin
                        state_d = ST_SLEEP;
                    end else if (ctrl_q[`WDR_CTRL_SYSCLK_BIT]) begin
                        state_d = ST_IDLE1;
                    end else begin
                        state_d = ST_IDLE0;
                    end
                end else if (clear_watchdog_instr) begin
                    wdt_clear = 1'b1;
                    pd_d      = 1'b0;
                end
            end
            ST_SLEEP, ST_IDLE0, ST_IDLE1: begin
                if (wdt.overflow) begin
                    exp_d      = 1'b1;
                    pd_d       = 1'b1;
                    pcsp_d     = 1'b1;
                    state_d    = ST_SETTLE;
                    sst_cnt_d  = 5'h00;
                    sst_slow_d = sys_src_slow;
                end else if (wake_req) begin
                    state_d    = ST_SETTLE;
                    sst_cnt_d  = 5'h00;
                    sst_slow_d = sys_src_slow;
                end
            end
            ST_SETTLE: begin
                // counting edges of the source gives N-1..N whole periods of settle time
                if ((sst_slow_q ? slow_tick : fast_tick)) begin
                    if (sst_cnt_q == 5'((sst_slow_q ? `WDR_SST_SLOW_EDGES : `WDR_SST_FAST_EDGES) - 1)) begin
                        state_d = ST_RUN;
                    end else begin
                        sst_cnt_d = 5'(sst_cnt_q + 5'h01);
                    end
                end
            end
            default: state_d = ST_HOLD;
        endcase

        if (full_reset) begin
            state_d    = ST_HOLD;
            hold_cnt_d = '0;
            ctrl_d     = `WDR_CTRL_RESET;
            pdata_d    = `WDR_PORT_RESET;
            pdir_d     = `WDR_PORT_RESET;
            pcsp_d     = 1'b1;
            wdt_clear  = 1'b1;
            // undervoltage keeps both flags; a running timeout sets expiry only
            if (!uv_fire) begin
                exp_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q    <= ST_HOLD;
            hold_cnt_q <= '0;
            sst_cnt_q  <= 5'h00;
            sst_slow_q <= 1'b0;
            ctrl_q     <= `WDR_CTRL_RESET;
            pdata_q    <= `WDR_PORT_RESET;
            pdir_q     <= `WDR_PORT_RESET;
            exp_q      <= 1'b0;
            pd_q       <= 1'b0;
            pcsp_q     <= 1'b1;
        end else begin
            state_q    <= state_d;
            hold_cnt_q <= hold_cnt_d;
            sst_cnt_q  <= sst_cnt_d;
            sst_slow_q <= sst_slow_d;
            ctrl_q     <= ctrl_d;
            pdata_q    <= pdata_d;
            pdir_q     <= pdir_d;
            exp_q      <= exp_d;
            pd_q       <= pd_d;
            pcsp_q     <= pcsp_d;
        end
    end

    // no enable bit exists: the timer always sees the slow tick
    assign wdt.tick       = slow_tick;
    assign wdt.clear      = wdt_clear;
    assign wdt.period_sel = ctrl_q[`WDR_CTRL_SEL_MSB:`WDR_CTRL_SEL_LSB];

    // read port, data the cycle after the strobe
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `WDR_ADDR_CTRL:      rdata_d = ctrl_q;
                `WDR_ADDR_STATUS:    rdata_d = {6'h00, pd_q, exp_q};
                `WDR_ADDR_PORT_DATA: rdata_d = pdata_q;
                `WDR_ADDR_PORT_DIR:  rdata_d = pdir_q;
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign core_reset    = (state_q == ST_HOLD);
    assign cpu_hold      = (state_q != ST_RUN);
    assign pc_sp_clear   = pcsp_q;
    assign sysclk_enable = (state_q != ST_SLEEP) && (state_q != ST_IDLE0);
    assign uv_threshold  = UV_THRESHOLD;
    assign port_out      = pdata_q;
    assign port_dir      = pdir_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_halt_sets_pd: assert property (
        state_q == ST_RUN && halt_instr && !full_reset |=> pd_q && !exp_q && wdt.count == 15'h0000)
        else $error("halt did not set powerdown and clear expiry");
    a_clear_drops_pd: assert property (
        state_q == ST_RUN && clear_watchdog_instr && !halt_instr && !full_reset |=> !pd_q)
        else $error("clear instruction left powerdown flag set");
    a_sleep_timeout: assert property (
        asleep && wdt.overflow && !uv_fire |=> exp_q && pd_q && pc_sp_clear && state_q == ST_SETTLE
        && ctrl_q == $past(ctrl_q) && pdata_q == $past(pdata_q))
        else $error("sleep timeout did not act as reduced reset");
    a_run_timeout: assert property (
        state_q == ST_RUN && wdt.overflow |=> core_reset && exp_q && ctrl_q == `WDR_CTRL_RESET)
        else $error("running timeout did not reset");
    a_uv_filter: assert property (
        $rose(core_reset) && !$past(wdt.overflow) |-> $past(uv_cnt_q) == 16'(UV_CYCLES - 1))
        else $error("undervoltage reset without full filter time");
    a_settle_exit: assert property (
        $past(state_q) == ST_SETTLE && state_q == ST_RUN
        |-> (sst_slow_q ? $past(slow_tick) : $past(fast_tick))
        && $past(sst_cnt_q) == 5'((sst_slow_q ? `WDR_SST_SLOW_EDGES : `WDR_SST_FAST_EDGES) - 1))
        else $error("settle ended before its edge count");
    a_idle_clock: assert property (
        state_q == ST_RUN && halt_instr && idle_select && !full_reset
        |=> sysclk_enable == $past(ctrl_q[`WDR_CTRL_SYSCLK_BIT]))
        else $error("idle clock choice wrong");
    a_reset_ports: assert property (
        $fell(core_reset) |-> $past(port_out) == 8'hFF || $past(reg_wr))
        else $error("ports not preset by reset");
    a_ctrl_storage: assert property (
        reg_wr && reg_addr == `WDR_ADDR_CTRL && !full_reset ##1 reg_rd && reg_addr == `WDR_ADDR_CTRL
        && !reg_wr && !full_reset |=> reg_rdata == $past(reg_wdata, 2))
        else $error("control register did not read back");

endmodule // wdr_top

`default_nettype wire

//--- wdr_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module wdr_cpu_model (
    input  wire logic ref_clk,
    input  wire logic cpu_hold,
    output logic      clear_watchdog_instr,
    output logic      halt_instr,
    output logic      idle_select,
    output logic      wake_req
);
    initial begin
        clear_watchdog_instr = 1'b0;
        halt_instr           = 1'b0;
        idle_select          = 1'b0;
        wake_req             = 1'b0;
    end

    // a stalled core issues nothing, so instructions wait for run
    task automatic wait_run();
        int n;
        n = 0;
        #1;
        while (cpu_hold !== 1'b0 && n < 5000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic exec_clear();
        wait_run();
        @(posedge ref_clk);
        clear_watchdog_instr <= 1'b1;
        @(posedge ref_clk);
        clear_watchdog_instr <= 1'b0;
    endtask

    task automatic exec_halt(input logic idle);
        wait_run();
        @(posedge ref_clk);
        idle_select <= idle;
        halt_instr  <= 1'b1;
        @(posedge ref_clk);
        halt_instr  <= 1'b0;
    endtask

    // wake comes from outside the core, so it does not wait for run
    task automatic pulse_wake();
        @(posedge ref_clk);
        wake_req <= 1'b1;
        @(posedge ref_clk);
        wake_req <= 1'b0;
    endtask
endmodule // wdr_cpu_model

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdr_defs.svh"

`define CHK(nm, exp, act) begin \
    cmp_count++; \
    if ((act) !== (exp)) begin \
        errors++; \
        $display("wrong value %s expected %0h seen %0h", nm, exp, act); \
    end \
end

module tb_top;
    localparam int POD   = 20;
    localparam int TICK  = 8;
    localparam int LIMIT = 60000;

    logic        ref_clk      = 1'b0;
    logic        rst_n        = 1'b0;
    logic        undervolt    = 1'b0;
    logic [1:0]  reg_addr     = 2'h0;
    logic [7:0]  reg_wdata    = 8'h00;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic        sys_src      = 1'b0;
    logic [2:0]  div_q        = 3'h0;
    logic        core_reset_p = 1'b0;
    int          errors       = 0;
    int          cmp_count    = 0;
    int          cyc          = 0;
    int          resets_seen  = 0;
    logic        clr_i;
    logic        halt_i;
    logic        idle_i;
    logic        wake_i;
    logic [7:0]  reg_rdata;
    logic        core_reset;
    logic        cpu_hold;
    logic        pc_sp_clear;
    logic        sysclk_enable;
    logic [1:0]  uv_threshold;
    logic [7:0]  port_out;
    logic [7:0]  port_dir;

    always #5 ref_clk = ~ref_clk;

    // both oscillators derived from the clock: slow period 8, fast period 4
    always @(posedge ref_clk) begin
        div_q        <= div_q + 3'h1;
        core_reset_p <= core_reset;
        if (core_reset === 1'b1 && core_reset_p === 1'b0) begin
            resets_seen++;
        end
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            report_and_stop();
        end
    end

    wdr_cpu_model cpu_u (
        .ref_clk              (ref_clk),
        .cpu_hold             (cpu_hold),
        .clear_watchdog_instr (clr_i),
        .halt_instr           (halt_i),
        .idle_select          (idle_i),
        .wake_req             (wake_i)
    );

    wdr_top #(.POD_CYCLES(POD), .UV_THRESHOLD(2'h2)) dut_u (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .slow_rc_osc          (div_q[2]),
        .fast_rc_osc          (div_q[1]),
        .sys_src_slow         (sys_src),
        .undervolt            (undervolt),
        .clear_watchdog_instr (clr_i),
        .halt_instr           (halt_i),
        .idle_select          (idle_i),
        .wake_req             (wake_i),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .core_reset           (core_reset),
        .cpu_hold             (cpu_hold),
        .pc_sp_clear          (pc_sp_clear),
        .sysclk_enable        (sysclk_enable),
        .uv_threshold         (uv_threshold),
        .port_out             (port_out),
        .port_dir             (port_dir)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(nm, exp, reg_rdata)
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rchk(input logic [1:0] a, input logic [7:0] d, input string nm);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge ref_clk);
        reg_rd    <= 1'b0;
        #1;
        `CHK(nm, d, reg_rdata)
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return core_reset;
            1: return pc_sp_clear;
            default: return cpu_hold;
        endcase
    endfunction

    task automatic wait_lvl(input int w, input logic lvl, input int max, output int n);
        n = 0;
        while (pick(w) !== lvl && n < max) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic t_reset();
        int n;
        repeat (5) @(posedge ref_clk);
        #1;
        `CHK("pc_sp_clear", 1'b1, pc_sp_clear)
        `CHK("port_dir", 8'hFF, port_dir)
        rst_n <= 1'b1;
        wait_lvl(0, 1'b0, 200, n);
        `CHK("hold length", 1'b1, (n >= POD && n <= POD + 3))
        rchk(`WDR_ADDR_CTRL, `WDR_CTRL_RESET, "ctrl");
        rchk(`WDR_ADDR_STATUS, 8'h00, "status");
        rchk(`WDR_ADDR_PORT_DATA, 8'hFF, "port data");
        rchk(`WDR_ADDR_PORT_DIR, 8'hFF, "port dir");
        `CHK("uv_threshold", 2'h2, uv_threshold)
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr_rchk(`WDR_ADDR_CTRL, 8'hF5, "ctrl rw");
        wr(`WDR_ADDR_STATUS, 8'hFF);
        rchk(`WDR_ADDR_STATUS, 8'h00, "status ro");
        wr(`WDR_ADDR_PORT_DATA, 8'h3C);
        rchk(`WDR_ADDR_PORT_DATA, 8'h3C, "port data rw");
        wr(`WDR_ADDR_PORT_DIR, 8'hA5);
        rchk(`WDR_ADDR_PORT_DIR, 8'hA5, "port dir rw");
        `CHK("port dir out", 8'hA5, port_dir)
        $display("test registers done");
    endtask

    // no clear after the first, so overflow must land one full period later
    task automatic t_run_timeout(input logic [2:0] sel);
        int n;
        int span;
        span = (256 << sel) * TICK;
        wr(`WDR_ADDR_PORT_DATA, 8'h00);
        wr(`WDR_ADDR_CTRL, {1'b0, sel, 4'h6});
        cpu_u.exec_clear();
        wait_lvl(0, 1'b1, span + 200, n);
        `CHK("timeout time", 1'b1, (n >= span - 3 * TICK && n <= span + 4 * TICK))
        wait_lvl(0, 1'b0, POD + 10, n);
        `CHK("timeout hold", 1'b1, (n >= POD - 1 && n <= POD + 1))
        `CHK("port after timeout", 8'hFF, port_out)
        `CHK("dir after timeout", 8'hFF, port_dir)
        rchk(`WDR_ADDR_STATUS, 8'h01, "status timeout");
        rchk(`WDR_ADDR_CTRL, `WDR_CTRL_RESET, "ctrl timeout");
        $display("test run timeout done");
    endtask

    task automatic t_undervolt();
        int n;
        int r0;
        r0 = resets_seen;
        @(posedge ref_clk);
        undervolt <= 1'b1;
        repeat (60) @(posedge ref_clk);
        undervolt <= 1'b0;
        repeat (150) @(posedge ref_clk);
        `CHK("short dip resets", r0, resets_seen)
        wr(`WDR_ADDR_CTRL, 8'h5C);
        @(posedge ref_clk);
        undervolt <= 1'b1;
        wait_lvl(0, 1'b1, 200, n);
        undervolt <= 1'b0;
        `CHK("filter time", 1'b1, (n >= 100 && n <= 110))
        wait_lvl(0, 1'b0, POD + 10, n);
        rchk(`WDR_ADDR_STATUS, 8'h01, "status uv");
        rchk(`WDR_ADDR_CTRL, `WDR_CTRL_RESET, "ctrl uv");
        $display("test undervoltage done");
    endtask

    task automatic t_keepalive();
        int r0;
        wr(`WDR_ADDR_CTRL, 8'h06);
        r0 = resets_seen;
        for (int i = 0; i < 5; i++) begin
            cpu_u.exec_clear();
            repeat (200 * TICK) @(posedge ref_clk);
        end
        `CHK("keepalive resets", r0, resets_seen)
        rchk(`WDR_ADDR_STATUS, 8'h01, "status clear");
        $display("test keepalive done");
    endtask

    task automatic t_sleep_timeout();
        int n;
        int r0;
        wr(`WDR_ADDR_PORT_DATA, 8'h55);
        cpu_u.exec_halt(1'b0);
        #1;
        `CHK("sleep hold", 1'b1, cpu_hold)
        `CHK("sleep clock", 1'b0, sysclk_enable)
        rchk(`WDR_ADDR_STATUS, 8'h02, "status halt");
        r0 = resets_seen;
        wait_lvl(1, 1'b1, 256 * TICK + 100, n);
        `CHK("sleep timeout time", 1'b1, (n >= 240 * TICK && n <= 256 * TICK + 40))
        wait_lvl(2, 1'b0, 150, n);
        `CHK("settle", 1'b1, (n >= 14 * 4 && n <= 16 * 4 + 20))
        `CHK("sleep resets", r0, resets_seen)
        `CHK("port kept", 8'h55, port_out)
        rchk(`WDR_ADDR_STATUS, 8'h03, "status sleep");
        rchk(`WDR_ADDR_CTRL, 8'h06, "ctrl kept");
        $display("test sleep timeout done");
    endtask

    task automatic t_idle_wake();
        int n;
        for (int b = 0; b < 2; b++) begin
            wr(`WDR_ADDR_CTRL, {b[0], 7'h06});
            cpu_u.exec_clear();
            sys_src <= b[0];
            cpu_u.exec_halt(1'b1);
            #1;
            `CHK("idle clock", b[0], sysclk_enable)
            `CHK("idle hold", 1'b1, cpu_hold)
            cpu_u.pulse_wake();
            wait_lvl(2, 1'b0, 150, n);
            `CHK("wake", 1'b0, cpu_hold)
            `CHK("wake settle", 1'b1, b[0] ? (n >= 8 && n <= 24) : (n >= 56 && n <= 84))
            rchk(`WDR_ADDR_STATUS, 8'h02, "status idle");
        end
        cpu_u.exec_clear();
        rchk(`WDR_ADDR_STATUS, 8'h00, "status pd clear");
        $display("test idle wake done");
    endtask

    initial begin
        t_reset();
        t_regs();
        t_run_timeout(3'h0);
        t_run_timeout(3'h1);
        t_undervolt();
        t_keepalive();
        t_sleep_timeout();
        t_idle_wake();
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
